// File: rtl/wake_cfg_pkg.sv
// shared constants and carrier types for the pwm and selective-wake register bank
package wake_cfg_pkg;

   // seven-bit register addresses on the serial control port
   localparam logic [6:0] SECOND_PWM_DUTY_ADDR   = 7'h19;
   localparam logic [6:0] PWM_FREQUENCY_ADDR     = 7'h1c;
   localparam logic [6:0] HOST_SCRATCH_ADDR      = 7'h1e;
   localparam logic [6:0] WAKE_CONTROL_ADDR      = 7'h20;
   localparam logic [6:0] WAKE_BIT_QUANTA_ADDR   = 7'h21;
   localparam logic [6:0] WAKE_SAMPLE_POINT_ADDR = 7'h22;

   // reset values
   localparam logic [7:0] SECOND_PWM_DUTY_RST   = 8'h00;
   localparam logic [7:0] PWM_FREQUENCY_RST     = 8'h00;
   localparam logic [7:0] HOST_SCRATCH_RST      = 8'h00;
   localparam logic [7:0] WAKE_CONTROL_RST      = 8'h00;
   localparam logic [7:0] WAKE_BIT_QUANTA_RST   = 8'ha0;
   localparam logic [5:0] WAKE_SAMPLE_POINT_RST = 6'h33;

   // duty extremes
   localparam logic [7:0] DUTY_FULL_OFF = 8'h00;
   localparam logic [7:0] DUTY_FULL_ON  = 8'hff;

   // field positions in the frequency register
   localparam int FIRST_RATE_BIT  = 0;
   localparam int SECOND_RATE_BIT = 2;

   // field positions in the wake control register
   localparam int TRIM_ENABLE_BIT   = 7;
   localparam int UNLOCK_HI_BIT     = 6;
   localparam int UNLOCK_LO_BIT     = 5;
   localparam int TIMEOUT_MASK_BIT  = 4;
   localparam int CONFIG_VALID_BIT  = 0;
   localparam logic [1:0] UNLOCK_CODE = 2'h3;

   // writable-bit masks, reserved positions are zero
   localparam logic [7:0] PWM_FREQUENCY_MASK     = 8'h05;
   localparam logic [7:0] WAKE_CONTROL_MASK      = 8'hf1;
   localparam logic [7:0] WAKE_SAMPLE_POINT_MASK = 8'h3f;
   localparam logic [7:0] FULL_BYTE_MASK         = 8'hff;

   // one register access as decoded by the serial port
   typedef struct packed {
      logic       write;
      logic       read;
      logic [6:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   // operating mode of the chip, one-hot levels
   typedef struct packed {
      logic normal;
      logic stop;
      logic failSafe;
   } chip_mode_t;

endpackage : wake_cfg_pkg

// File: rtl/pwm_wake_cfg_regs.sv
// pwm duty and rate, host scratch byte and selective-wake configuration registers

// Operation
// - duty zero off, all ones on, else value/255
// - duty at 0x19, clears on reset, restart keeps
// - rate select bits 0 and 2, 200/400 Hz
// - reserved bits read as zero
// - scratch byte cleared at power-up, survives soft reset
// - scratch accessible only in normal mode
// - chip logic never alters scratch byte
// - wake control bit 7 enables oscillator trimming
// - trim unlock only when field is 11
// - host drives transmit pin as trim reference
// - unlock code also permits option register writes
// - bit 4 gates timeout onto alert pin
// - timeout flag, alert only with wake enabled
// - wake enabled only while config-valid bit set
// - config-valid clears on wake, reset, config change
// - stop-mode config write clears config-valid
// - quanta per bit field resets to 0xa0
// - sample point six bits, resets to 0x33
module pwm_wake_cfg_regs (
   // clock and power-on reset
   input  wire logic                     mclk,
   input  wire logic                     rst_n,
   // register access from the serial control port
   input  wire wake_cfg_pkg::reg_req_t   regReq,
   output logic [7:0]                    regRdata_r,
   output logic                          regRvalid_r,
   // chip state and events
   input  wire wake_cfg_pkg::chip_mode_t chipMode,
   input  wire logic                     softReset,
   input  wire logic                     restartEntry,
   input  wire logic                     wakeEvent,
   input  wire logic                     canConfigWrite,
   input  wire logic                     busTimeout,
   input  wire logic                     busTimeoutClear,
   // pwm generator controls
   output logic [7:0]                    secondDuty_r,
   output logic                          secondFullOff_r,
   output logic                          secondFullOn_r,
   output logic                          firstRate400_r,
   output logic                          secondRate400_r,
   // oscillator trimming and option register gate
   output logic                          oscillatorTrimEnable_r,
   output logic                          trimUnlocked_r,
   output logic                          optionWriteAllowed_r,
   // selective wake state
   output logic                          wakeConfigValid_r,
   output logic                          selectiveWakeEnable_r,
   output logic                          busTimeoutFlag_r,
   output logic                          hostAlert_r,
   // bit timing
   output logic [7:0]                    quantaPerBit_r,
   output logic [5:0]                    samplePointFraction_r,
   // host scratch byte
   output logic [7:0]                    hostScratch_r
);

   // writable-bit mask of each mapped address, zero for unmapped ones
   function automatic logic [7:0] writeMask(input logic [6:0] addr);
      case (addr)
         wake_cfg_pkg::SECOND_PWM_DUTY_ADDR:   writeMask = wake_cfg_pkg::FULL_BYTE_MASK;
         wake_cfg_pkg::PWM_FREQUENCY_ADDR:     writeMask = wake_cfg_pkg::PWM_FREQUENCY_MASK;
         wake_cfg_pkg::HOST_SCRATCH_ADDR:      writeMask = wake_cfg_pkg::FULL_BYTE_MASK;
         wake_cfg_pkg::WAKE_CONTROL_ADDR:      writeMask = wake_cfg_pkg::WAKE_CONTROL_MASK;
         wake_cfg_pkg::WAKE_BIT_QUANTA_ADDR:   writeMask = wake_cfg_pkg::FULL_BYTE_MASK;
         wake_cfg_pkg::WAKE_SAMPLE_POINT_ADDR: writeMask = wake_cfg_pkg::WAKE_SAMPLE_POINT_MASK;
         default:                              writeMask = 8'h00;
      endcase
   endfunction : writeMask

   // stored register images, reserved bits kept at zero
   logic [7:0] freqReg_r;        // frequency register image
   logic [7:0] wakeCtrl_r;       // wake control register image
   logic [7:0] wakeCtrl_nxt;     // next wake control image
   logic [7:0] maskedWdata;      // write data with reserved bits stripped
   logic [7:0] readMux;          // read data before registering

   // write strobes per register
   logic wrDuty;
   logic wrFreq;
   logic wrScratch;
   logic wrWakeCtrl;
   logic wrQuanta;
   logic wrSample;
   logic wakeDataChange;         // host changed selective-wake data
   logic stopConfigWrite;        // config write while in stop mode
   logic timeoutVisible;         // timeout may be reported now

   assign maskedWdata = regReq.wdata & writeMask(regReq.addr);
   assign wrDuty      = regReq.write && regReq.addr == wake_cfg_pkg::SECOND_PWM_DUTY_ADDR;
   assign wrFreq      = regReq.write && regReq.addr == wake_cfg_pkg::PWM_FREQUENCY_ADDR;
   assign wrScratch   = regReq.write && regReq.addr == wake_cfg_pkg::HOST_SCRATCH_ADDR
                        && chipMode.normal;
   assign wrWakeCtrl  = regReq.write && regReq.addr == wake_cfg_pkg::WAKE_CONTROL_ADDR;
   assign wrQuanta    = regReq.write && regReq.addr == wake_cfg_pkg::WAKE_BIT_QUANTA_ADDR;
   assign wrSample    = regReq.write && regReq.addr == wake_cfg_pkg::WAKE_SAMPLE_POINT_ADDR;

   // bit-timing writes and external id/mask/length writes are config changes
   assign wakeDataChange  = wrQuanta || wrSample || canConfigWrite;
   // in stop mode the control register write counts too
   assign stopConfigWrite = chipMode.stop && (wakeDataChange || wrWakeCtrl);

   // second pwm duty: cleared by power-on and soft reset, restart leaves it
   always_ff @(posedge mclk) begin
      if (!rst_n || softReset) begin
         secondDuty_r <= wake_cfg_pkg::SECOND_PWM_DUTY_RST;
      end else if (wrDuty) begin
         secondDuty_r <= maskedWdata;
      end
   end

   // extreme duty decode for the waveform generator
   always_ff @(posedge mclk) begin
      if (!rst_n || softReset) begin
         secondFullOff_r <= 1'b1;
         secondFullOn_r  <= 1'b0;
      end else if (wrDuty) begin
         secondFullOff_r <= maskedWdata == wake_cfg_pkg::DUTY_FULL_OFF;
         secondFullOn_r  <= maskedWdata == wake_cfg_pkg::DUTY_FULL_ON;
      end
   end

   // frequency register; restart keeps the selects
   always_ff @(posedge mclk) begin
      if (!rst_n || softReset) begin
         freqReg_r <= wake_cfg_pkg::PWM_FREQUENCY_RST;
      end else if (wrFreq) begin
         freqReg_r <= maskedWdata;
      end
   end

   // rate selects driven from flops, one means 400 Hz
   always_ff @(posedge mclk) begin
      if (!rst_n || softReset) begin
         firstRate400_r  <= 1'b0;
         secondRate400_r <= 1'b0;
      end else if (wrFreq) begin
         firstRate400_r  <= maskedWdata[wake_cfg_pkg::FIRST_RATE_BIT];
         secondRate400_r <= maskedWdata[wake_cfg_pkg::SECOND_RATE_BIT];
      end
   end

   // scratch byte: power-on only, soft reset and modes never touch it
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         hostScratch_r <= wake_cfg_pkg::HOST_SCRATCH_RST;
      end else if (wrScratch) begin
         hostScratch_r <= maskedWdata;
      end
   end

   // next wake control image: host write, then hardware clears of the valid bit
   always_comb begin
      wakeCtrl_nxt = wakeCtrl_r;
      if (wrWakeCtrl) begin
         wakeCtrl_nxt = maskedWdata;
      end
      if (restartEntry) begin
         wakeCtrl_nxt[3:0] = 4'h0; // low nibble has a defined restart value
      end
      // hardware clear outranks a simultaneous host set
      if (wakeEvent || wakeDataChange || stopConfigWrite) begin
         wakeCtrl_nxt[wake_cfg_pkg::CONFIG_VALID_BIT] = 1'b0;
      end
   end

   // wake control register
   always_ff @(posedge mclk) begin
      if (!rst_n || softReset) begin
         wakeCtrl_r <= wake_cfg_pkg::WAKE_CONTROL_RST;
      end else begin
         wakeCtrl_r <= wakeCtrl_nxt;
      end
   end

   // decoded trimming and wake controls, registered from the next image
   always_ff @(posedge mclk) begin
      if (!rst_n || softReset) begin
         oscillatorTrimEnable_r <= 1'b0;
         trimUnlocked_r         <= 1'b0;
         optionWriteAllowed_r   <= 1'b0;
         wakeConfigValid_r      <= 1'b0;
         selectiveWakeEnable_r  <= 1'b0;
      end else begin
         // trimming uses the transmit pin as reference outside this block
         oscillatorTrimEnable_r <= wakeCtrl_nxt[wake_cfg_pkg::TRIM_ENABLE_BIT];
         trimUnlocked_r         <= wakeCtrl_nxt[wake_cfg_pkg::UNLOCK_HI_BIT:
                                                wake_cfg_pkg::UNLOCK_LO_BIT]
                                   == wake_cfg_pkg::UNLOCK_CODE;
         optionWriteAllowed_r   <= wakeCtrl_nxt[wake_cfg_pkg::UNLOCK_HI_BIT:
                                                wake_cfg_pkg::UNLOCK_LO_BIT]
                                   == wake_cfg_pkg::UNLOCK_CODE;
         wakeConfigValid_r      <= wakeCtrl_nxt[wake_cfg_pkg::CONFIG_VALID_BIT];
         selectiveWakeEnable_r  <= wakeCtrl_nxt[wake_cfg_pkg::CONFIG_VALID_BIT];
      end
   end

   // timeout reported only with selective wake on, in normal or stop mode
   assign timeoutVisible = selectiveWakeEnable_r && (chipMode.normal || chipMode.stop);

   // timeout status flag: set only while selective wake is on, clear works at any time, set wins
   always_ff @(posedge mclk) begin
      if (!rst_n || softReset) begin
         busTimeoutFlag_r <= 1'b0;
      end else if (busTimeout && selectiveWakeEnable_r) begin
         busTimeoutFlag_r <= 1'b1;
      end else if (busTimeoutClear) begin
         busTimeoutFlag_r <= 1'b0;
      end
   end

   // one-cycle alert request, gated by the timeout mask bit
   always_ff @(posedge mclk) begin
      if (!rst_n || softReset) begin
         hostAlert_r <= 1'b0;
      end else begin
         hostAlert_r <= busTimeout && timeoutVisible
                        && wakeCtrl_r[wake_cfg_pkg::TIMEOUT_MASK_BIT];
      end
   end

   // bit timing registers
   always_ff @(posedge mclk) begin
      if (!rst_n || softReset) begin
         quantaPerBit_r        <= wake_cfg_pkg::WAKE_BIT_QUANTA_RST;
         samplePointFraction_r <= wake_cfg_pkg::WAKE_SAMPLE_POINT_RST;
      end else begin
         if (wrQuanta) begin
            quantaPerBit_r <= maskedWdata;
         end
         if (wrSample) begin
            samplePointFraction_r <= maskedWdata[5:0];
         end
      end
   end

   // read multiplexer; scratch reads as zero outside normal mode
   always_comb begin
      case (regReq.addr)
         wake_cfg_pkg::SECOND_PWM_DUTY_ADDR:   readMux = secondDuty_r;
         wake_cfg_pkg::PWM_FREQUENCY_ADDR:     readMux = freqReg_r;
         wake_cfg_pkg::HOST_SCRATCH_ADDR:
            readMux = chipMode.normal ? hostScratch_r : 8'h00;
         wake_cfg_pkg::WAKE_CONTROL_ADDR:      readMux = wakeCtrl_r;
         wake_cfg_pkg::WAKE_BIT_QUANTA_ADDR:   readMux = quantaPerBit_r;
         wake_cfg_pkg::WAKE_SAMPLE_POINT_ADDR: readMux = {2'b00, samplePointFraction_r};
         default:                              readMux = 8'h00;
      endcase
   end

   // registered read answer, one cycle after the request
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         regRdata_r  <= 8'h00;
         regRvalid_r <= 1'b0;
      end else begin
         regRvalid_r <= regReq.read;
         if (regReq.read) begin
            regRdata_r <= readMux & writeMask(regReq.addr);
         end
      end
   end

   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   property p_dutyWrite;
      wrDuty && !softReset |=> secondDuty_r == $past(regReq.wdata)
                               && secondFullOn_r == ($past(regReq.wdata) == 8'hff)
                               && secondFullOff_r == ($past(regReq.wdata) == 8'h00);
   endproperty
   a_dutyWrite: assert property (p_dutyWrite) else $error("duty write lost");

   property p_dutyRestart;
      restartEntry && !softReset && !wrDuty |=> $stable(secondDuty_r);
   endproperty
   a_dutyRestart: assert property (p_dutyRestart) else $error("restart altered duty");

   property p_reservedZero;
      regReq.read && regReq.addr == wake_cfg_pkg::PWM_FREQUENCY_ADDR
      |=> regRdata_r[7:3] == 5'h0 && !regRdata_r[1];
   endproperty
   a_reservedZero: assert property (p_reservedZero) else $error("reserved bits nonzero");

   property p_scratchKeep;
      (softReset || !chipMode.normal) |=> $stable(hostScratch_r);
   endproperty
   a_scratchKeep: assert property (p_scratchKeep) else $error("scratch byte changed");

   property p_unlock;
      wrWakeCtrl && !softReset |=> trimUnlocked_r == ($past(regReq.wdata[6:5]) == 2'h3)
                                   && optionWriteAllowed_r == trimUnlocked_r;
   endproperty
   a_unlock: assert property (p_unlock) else $error("unlock without code");

   property p_alertMasked;
      !wakeCtrl_r[4] |=> !hostAlert_r;
   endproperty
   a_alertMasked: assert property (p_alertMasked) else $error("masked timeout alerted");

   property p_flagOnlyEnabled;
      !selectiveWakeEnable_r && !softReset |=> !$rose(busTimeoutFlag_r);
   endproperty
   a_flagOnlyEnabled: assert property (p_flagOnlyEnabled) else $error("flag set while off");

   property p_wakeClears;
      (wakeEvent || wakeDataChange || stopConfigWrite) |=> !wakeConfigValid_r
                                                        && !selectiveWakeEnable_r;
   endproperty
   a_wakeClears: assert property (p_wakeClears) else $error("valid bit not cleared");

   property p_stopWrite;
      chipMode.stop && wrWakeCtrl |=> !wakeConfigValid_r && !selectiveWakeEnable_r;
   endproperty
   a_stopWrite: assert property (p_stopWrite) else $error("stop write kept valid");

   // both rate selects follow the written bits
   property p_rateWrite;
      wrFreq && !softReset |=> firstRate400_r == $past(regReq.wdata[0])
                               && secondRate400_r == $past(regReq.wdata[2]);
   endproperty
   a_rateWrite: assert property (p_rateWrite) else $error("rate select lost");

   property p_wakeReadZero;
      regReq.read && regReq.addr == wake_cfg_pkg::WAKE_CONTROL_ADDR |=> regRdata_r[3:1] == 3'h0;
   endproperty
   a_wakeReadZero: assert property (p_wakeReadZero) else $error("bits 3:1 set");

   property p_sampleReadZero;
      regReq.read && regReq.addr == wake_cfg_pkg::WAKE_SAMPLE_POINT_ADDR
      |=> regRdata_r[7:6] == 2'h0;
   endproperty
   a_sampleReadZero: assert property (p_sampleReadZero) else $error("bits 7:6 set");

   // scratch contents never leak outside normal mode
   property p_scratchRead;
      regReq.read && regReq.addr == wake_cfg_pkg::HOST_SCRATCH_ADDR && !chipMode.normal
      |=> regRdata_r == 8'h00;
   endproperty
   a_scratchRead: assert property (p_scratchRead) else $error("scratch leaked");

   property p_alertMode;
      busTimeout && !(chipMode.normal || chipMode.stop) |=> !hostAlert_r;
   endproperty
   a_alertMode: assert property (p_alertMode) else $error("alert in wrong mode");

   c_enable: cover property (wrWakeCtrl && regReq.wdata[0] && chipMode.normal ##1 selectiveWakeEnable_r);
   c_alert:  cover property (hostAlert_r);
   c_unlock: cover property ($rose(trimUnlocked_r));
   c_scratchSoft: cover property (softReset && hostScratch_r != 8'h00);

endmodule : pwm_wake_cfg_regs

// File: verif/host_port_model.sv
// host microcontroller model issuing single-byte accesses on the register port
module host_port_model (
   // clock
   input  wire logic              mclk,
   // register port towards the device
   output wake_cfg_pkg::reg_req_t regReq,
   input  wire logic [7:0]        regRdata_r,
   input  wire logic              regRvalid_r
);
   timeunit 1ns;
   timeprecision 1ps;

   // port idles from time zero
   initial begin
      regReq = '0;
   end

   // one write, held for exactly one taken edge
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] v;
      v = d;
      // a one-step duty cannot be realized, so the host never programs it
      if (a == wake_cfg_pkg::SECOND_PWM_DUTY_ADDR && v == 8'h01) begin
         v = 8'h02;
      end
      @(posedge mclk) #1;
      regReq = '{write: 1'b1, read: 1'b0, addr: a, wdata: v};
      @(posedge mclk) #1;
      regReq.write = 1'b0;
   endtask : wr

   // one read, answer taken the cycle after the request edge
   task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic v);
      @(posedge mclk) #1;
      regReq = '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
      @(posedge mclk) #1;
      regReq.read = 1'b0;
      d = regRdata_r;
      v = regRvalid_r;
   endtask : rd

endmodule : host_port_model

// File: verif/tb_top.sv
// self-checking bench for the pwm and selective-wake register bank
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic                     mclk, rst_n;   // clock and power-on reset
   wake_cfg_pkg::reg_req_t   regReq;        // driven by the host model
   wake_cfg_pkg::chip_mode_t chipMode;      // one-hot operating mode
   logic [5:0]               evts;          // soft,restart,wake,cancfg,tout,toutclr
   logic [7:0]               rdata, duty, quanta, scratch, got;
   logic [5:0]               sample;        // sample point output
   logic                     rvalid, offS, onS, rate1, rate2, trimEn, unl, optW;
   logic                     cfgVal, swkEn, toFlag, alert, gotV;
   int                       failCount, nCompared;

   // device under test
   pwm_wake_cfg_regs i_pwm_wake_cfg_regs (
      .mclk(mclk), .rst_n(rst_n), .regReq(regReq), .regRdata_r(rdata),
      .regRvalid_r(rvalid), .chipMode(chipMode), .softReset(evts[5]),
      .restartEntry(evts[4]), .wakeEvent(evts[3]), .canConfigWrite(evts[2]),
      .busTimeout(evts[1]), .busTimeoutClear(evts[0]), .secondDuty_r(duty),
      .secondFullOff_r(offS), .secondFullOn_r(onS), .firstRate400_r(rate1),
      .secondRate400_r(rate2), .oscillatorTrimEnable_r(trimEn),
      .trimUnlocked_r(unl), .optionWriteAllowed_r(optW),
      .wakeConfigValid_r(cfgVal), .selectiveWakeEnable_r(swkEn),
      .busTimeoutFlag_r(toFlag), .hostAlert_r(alert), .quantaPerBit_r(quanta),
      .samplePointFraction_r(sample), .hostScratch_r(scratch));

   // host on the serial control port
   host_port_model i_host_port_model (
      .mclk(mclk), .regReq(regReq), .regRdata_r(rdata), .regRvalid_r(rvalid));

   // 8 ns clock
   always #4 mclk = ~mclk;

   // byte and bit comparisons
   task automatic cmpByte(input logic [7:0] g, input logic [7:0] e);
      nCompared++;
      if (g !== e) begin
         failCount++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : cmpByte

   task automatic cmpBit(input logic g, input logic e);
      cmpByte({7'h00, g}, {7'h00, e});
   endtask : cmpBit

   // read a register and check valid strobe and data
   task automatic rdChk(input logic [6:0] a, input logic [7:0] e);
      i_host_port_model.rd(a, got, gotV);
      cmpBit(gotV, 1'b1);
      cmpByte(got, e);
   endtask : rdChk

   // one-cycle event pulse on the chosen inputs
   task automatic pulse(input logic [5:0] m);
      @(posedge mclk) #1 evts = m;
      @(posedge mclk) #1 evts = 6'h00;
   endtask : pulse

   // reset values, then all-ones writes to expose reserved bits
   task automatic regTable();
      logic [6:0] a [6];
      logic [7:0] r [6];
      logic [7:0] m [6];
      a = '{7'h19, 7'h1c, 7'h1e, 7'h20, 7'h21, 7'h22};
      r = '{8'h00, 8'h00, 8'h00, 8'h00, 8'ha0, 8'h33};
      m = '{8'hff, 8'h05, 8'hff, 8'hf1, 8'hff, 8'h3f};
      for (int i = 0; i < 6; i++) begin
         rdChk(a[i], r[i]);
         i_host_port_model.wr(a[i], 8'hff);
         rdChk(a[i], m[i]);
      end
      rdChk(7'h1f, 8'h00);
      cmpByte({2'b00, sample}, 8'h3f);
   endtask : regTable

   // duty extremes and rate selects
   task automatic pwmScan();
      logic [7:0] d [4];
      d = '{8'h00, 8'hff, 8'h80, 8'hfe};
      for (int i = 0; i < 4; i++) begin
         i_host_port_model.wr(7'h19, d[i]);
         cmpBit(offS, d[i] == 8'h00);
         cmpBit(onS, d[i] == 8'hff);
         rdChk(7'h19, d[i]);
      end
      for (int k = 0; k < 4; k++) begin
         i_host_port_model.wr(7'h1c, {5'h00, k[1], 1'b0, k[0]});
         cmpBit(rate1, k[0]);
         cmpBit(rate2, k[1]);
      end
   endtask : pwmScan

   // every trim enable and unlock code
   task automatic trimScan();
      for (int k = 0; k < 8; k++) begin
         i_host_port_model.wr(7'h20, {k[2], k[1:0], 5'h00});
         cmpBit(trimEn, k[2]);
         cmpBit(unl, k[1:0] == 2'b11);
         cmpBit(optW, k[1:0] == 2'b11);
      end
   endtask : trimScan

   // valid set by host, then each hardware clear source
   task automatic wakeValid();
      for (int k = 0; k < 6; k++) begin
         chipMode = 3'b100;
         i_host_port_model.wr(7'h20, 8'h01);
         cmpBit(cfgVal & swkEn, 1'b1);
         case (k)
            0: pulse(6'h08);
            1: i_host_port_model.wr(7'h21, 8'h80);
            2: pulse(6'h04);
            3: pulse(6'h10);
            4: begin
               chipMode = 3'b010;
               i_host_port_model.wr(7'h22, 8'h20);
            end
            default: begin
               // stop-mode write of the control register itself, even one setting valid
               chipMode = 3'b010;
               i_host_port_model.wr(7'h20, 8'h01);
            end
         endcase
         cmpBit(cfgVal | swkEn, 1'b0);
      end
      chipMode = 3'b100;
   endtask : wakeValid

   // timeout with alert unmasked, masked, and wake disabled
   task automatic timeoutPath();
      logic [7:0] c [3];
      c = '{8'h11, 8'h01, 8'h10};
      for (int i = 0; i < 3; i++) begin
         i_host_port_model.wr(7'h20, c[i]);
         pulse(6'h02);
         cmpBit(alert, c[i] == 8'h11);
         cmpBit(toFlag, c[i][0]);
         @(posedge mclk) #1;
         cmpBit(alert, 1'b0);
         pulse(6'h01);
         cmpBit(toFlag, 1'b0);
      end
      // fail-safe: flag still follows the timeout, alert stays quiet
      chipMode = 3'b001;
      i_host_port_model.wr(7'h20, 8'h11);
      pulse(6'h02);
      cmpBit(alert, 1'b0);
      cmpBit(toFlag, 1'b1);
      pulse(6'h01);
      chipMode = 3'b100;
   endtask : timeoutPath

   // scratch byte across modes, restart, soft reset and power-on reset
   task automatic scratchKeep();
      i_host_port_model.wr(7'h1e, 8'h5a);
      rdChk(7'h1e, 8'h5a);
      chipMode = 3'b010;
      i_host_port_model.wr(7'h1e, 8'h11);
      cmpByte(scratch, 8'h5a);
      rdChk(7'h1e, 8'h00);
      chipMode = 3'b001;
      pulse(6'h10);
      cmpByte(scratch, 8'h5a);
      chipMode = 3'b100;
      i_host_port_model.wr(7'h19, 8'h40);
      pulse(6'h10);
      cmpByte(duty, 8'h40);
      pulse(6'h20);
      cmpByte(duty, 8'h00);
      cmpByte(quanta, 8'ha0);
      cmpByte(scratch, 8'h5a);
      @(posedge mclk) #1 rst_n = 1'b0;
      @(posedge mclk) #1 rst_n = 1'b1;
      cmpByte(scratch, 8'h00);
   endtask : scratchKeep

   // verdict and end of run
   task automatic results();
      if (failCount == 0 && nCompared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : results

   // main sequence
   initial begin
      mclk = 1'b0;
      rst_n = 1'b0;
      chipMode = 3'b100;
      evts = 6'h00;
      failCount = 0;
      nCompared = 0;
      repeat (20) @(posedge mclk);
      #1 rst_n = 1'b1;
      regTable();
      pwmScan();
      trimScan();
      wakeValid();
      timeoutPath();
      scratchKeep();
      results();
   end

   // watchdog against a hang
   initial begin
      repeat (20000) @(posedge mclk);
      failCount++;
      results();
   end

endmodule : tb_top
